// *** design/rmpu_region_match.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rmpu_defs.svh"

module rmpu_region_match (
	// region settings
	input  wire logic [26:0]          base,
	input  wire rmpu_pkg::rmpu_attr_t attr,
	// probe address
	input  wire logic [31:0]          addr,
	// match
	output logic                      hit
);
	logic [5:0]  span_bits;
	logic [32:0] low_mask;
	logic [5:0]  sub_shift;
	logic [31:0] sub_word;
	logic        in_range;
	logic        sub_off;

	always_comb begin
		span_bits = {1'b0, attr.size} + 6'h01;
		low_mask  = (33'h1 << span_bits) - 33'h1;
		in_range  = (((addr ^ {base, 5'h00}) & ~low_mask[31:0]) == 32'h0);
		sub_shift = span_bits - 6'h03;
		sub_word  = addr >> sub_shift;
		sub_off   = (attr.size >= `RMPU_SIZE_SUBREG) && attr.subregion_disable_mask[sub_word[2:0]];
		hit       = attr.en && (attr.size >= `RMPU_SIZE_MIN) && in_range && !sub_off;
	end

endmodule // rmpu_region_match
`default_nettype wire

// *** design/rmpu_top.sv ***
// Behaviour
// - eight regions 0..7 plus a background region, each with own settings
// - overlapping hits take the attributes of the highest numbered region
// - background region gives default map, privileged accesses only
// - fetches and data accesses share one set of region settings
// - a prohibited access raises a memory management fault
// - missing permission (access field, never-execute) flags a permission fault
// - attribute/size register takes byte, halfword and word writes per lane
// - select, base, attribute writes singly or in bursts hit selected region
// - alias copies of base and attribute let one burst program four regions
// - base write with bit 4 set also loads the region selection
// - regions of 256 bytes or more split into eight disableable subregions
// - mask lsb is lowest subregion, msb the highest
// - disabled subregion falls to other regions, else to the background region rule
// - type 000 decodes strongly ordered, device, normal write-through
// - type 001 decodes non-cacheable or write-back, mixed codes reserved
// - type 1BB gives normal cached memory, outer and inner policies
// - shareable bit ignored for strongly ordered, device, reserved codes
// - every attribute encoding accepted, none changes access behaviour
`timescale 1ns/1ps
`default_nettype none
`include "rmpu_defs.svh"

module rmpu_top #(
	parameter int NUM_REGIONS = 8
) (
	// clock, reset, enable
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       ce,
	// axi4-lite write
	input  wire logic [`RMPU_ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// axi4-lite read
	input  wire logic [`RMPU_ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// access check
	input  wire logic                       acc_valid,
	input  wire rmpu_pkg::rmpu_access_t     acc,
	output logic                            chk_valid,
	output var rmpu_pkg::rmpu_result_t      chk_result,
	output logic                            mpu_active
);

	if (NUM_REGIONS < 1 || NUM_REGIONS > 8) begin : g_bad_count
		$error("rmpu_top: NUM_REGIONS must be 1 to 8");
	end

	logic                       ctrl_en_r;
	logic                       privdef_r;
	logic [2:0]                 sel_r;
	logic [26:0]                base_r [NUM_REGIONS];
	logic [31:0]                attr_r [NUM_REGIONS];
	logic                       aw_full_r;
	logic [`RMPU_ADDR_W-1:0]    aw_addr_r;
	logic                       w_full_r;
	logic [31:0]                w_data_r;
	logic [3:0]                 w_strb_r;
	logic                       bvalid_r;
	logic [1:0]                 bresp_r;
	logic                       rvalid_r;
	logic [1:0]                 rresp_r;
	logic [31:0]                rdata_r;
	logic                       chk_valid_r;
	rmpu_pkg::rmpu_result_t     res_r;
	logic                       wr_fire;
	logic                       rd_fire;
	logic                       wr_is_base;
	logic                       wr_is_attr;
	logic                       wr_known;
	logic [2:0]                 wr_sel;
	logic [31:0]                attr_nxt;
	logic [31:0]                rd_nxt;
	logic [1:0]                 rd_resp_nxt;
	logic [NUM_REGIONS-1:0]     hit_vec;
	logic                       any_hit;
	logic [2:0]                 win;
	rmpu_pkg::rmpu_attr_t       win_attr;
	rmpu_pkg::rmpu_result_t     res_nxt;

	function automatic logic is_base(input logic [`RMPU_ADDR_W-1:0] a);
		return a == `RMPU_OFF_BASE || a == `RMPU_OFF_BASE1 ||
			a == `RMPU_OFF_BASE2 || a == `RMPU_OFF_BASE3;
	endfunction

	function automatic logic is_attr(input logic [`RMPU_ADDR_W-1:0] a);
		return a == `RMPU_OFF_ATTR || a == `RMPU_OFF_ATTR1 ||
			a == `RMPU_OFF_ATTR2 || a == `RMPU_OFF_ATTR3;
	endfunction

	// permission table indexed by access field
	function automatic logic perm_ok(input logic [2:0] ap, input logic priv,
		input logic write);
		case (ap)
			3'h0: return 1'b0;
			3'h1: return priv;
			3'h2: return priv || !write;
			3'h3: return 1'b1;
			3'h5: return priv && !write;
			3'h6: return !write;
			3'h7: return !write;
			default: return 1'b0;
		endcase
	endfunction

	// ---------------- bus slave ----------------
	assign s_axi_awready = ce && !aw_full_r;
	assign s_axi_wready  = ce && !w_full_r;
	assign s_axi_arready = ce && !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign wr_fire       = aw_full_r && w_full_r && !bvalid_r;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign wr_is_base    = is_base(aw_addr_r);
	assign wr_is_attr    = is_attr(aw_addr_r);
	assign wr_known      = wr_is_base || wr_is_attr || aw_addr_r == `RMPU_OFF_CTRL ||
		aw_addr_r == `RMPU_OFF_SELECT || aw_addr_r == `RMPU_OFF_TYPE;

	// address and data are taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `RMPU_RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_known ? `RMPU_RESP_OKAY : `RMPU_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_sel = sel_r;
		if (wr_is_base && w_data_r[`RMPU_BASE_VALID_BIT] && (&w_strb_r)) begin
			wr_sel = w_data_r[2:0];
		end
	end

	always_comb begin
		attr_nxt = 32'h0;
		if (int'(sel_r) < NUM_REGIONS) begin
			attr_nxt = attr_r[sel_r];
		end
		for (int i = 0; i < 4; i++) begin
			if (w_strb_r[i]) begin
				attr_nxt[8*i +: 8] = w_data_r[8*i +: 8];
			end
		end
		attr_nxt = attr_nxt & `RMPU_ATTR_WMASK;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_en_r <= 1'(`RMPU_CTRL_RESET >> `RMPU_CTRL_EN_BIT);
			privdef_r <= 1'(`RMPU_CTRL_RESET >> `RMPU_CTRL_PRIVDEF_BIT);
		end else if (ce && wr_fire && aw_addr_r == `RMPU_OFF_CTRL && (&w_strb_r)) begin
			ctrl_en_r <= w_data_r[`RMPU_CTRL_EN_BIT];
			privdef_r <= w_data_r[`RMPU_CTRL_PRIVDEF_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_r <= `RMPU_SEL_RESET;
		end else if (ce && wr_fire && (&w_strb_r)) begin
			if (aw_addr_r == `RMPU_OFF_SELECT) begin
				sel_r <= w_data_r[2:0];
			end else if (wr_is_base) begin
				sel_r <= wr_sel;
			end
		end
	end

	for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_store
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				base_r[g] <= `RMPU_BASE_RESET;
				attr_r[g] <= `RMPU_ATTR_RESET;
			end else if (ce && wr_fire) begin
				if (wr_is_base && (&w_strb_r) && wr_sel == 3'(g)) begin
					base_r[g] <= w_data_r[31:`RMPU_BASE_ADDR_LSB];
				end
				if (wr_is_attr && sel_r == 3'(g)) begin
					attr_r[g] <= attr_nxt;
				end
			end
		end
	end

	always_comb begin
		rd_nxt      = 32'h0;
		rd_resp_nxt = `RMPU_RESP_OKAY;
		if (s_axi_araddr == `RMPU_OFF_TYPE) begin
			rd_nxt[`RMPU_TYPE_COUNT_LSB +: 8] = 8'(NUM_REGIONS);
		end else if (s_axi_araddr == `RMPU_OFF_CTRL) begin
			rd_nxt[`RMPU_CTRL_EN_BIT]      = ctrl_en_r;
			rd_nxt[`RMPU_CTRL_PRIVDEF_BIT] = privdef_r;
		end else if (s_axi_araddr == `RMPU_OFF_SELECT) begin
			rd_nxt[2:0] = sel_r;
		end else if (is_base(s_axi_araddr)) begin
			rd_nxt[2:0] = sel_r;
			if (int'(sel_r) < NUM_REGIONS) begin
				rd_nxt[31:`RMPU_BASE_ADDR_LSB] = base_r[sel_r];
			end
		end else if (is_attr(s_axi_araddr)) begin
			if (int'(sel_r) < NUM_REGIONS) begin
				rd_nxt = attr_r[sel_r];
			end
		end else begin
			rd_resp_nxt = `RMPU_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= `RMPU_RESP_OKAY;
			rdata_r  <= 32'h0;
		end else if (ce) begin
			if (rd_fire) begin
				rvalid_r <= 1'b1;
				rresp_r  <= rd_resp_nxt;
				rdata_r  <= rd_nxt;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ---------------- access check ----------------
	// one matcher per region
	for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_match
		rmpu_region_match u_match (
			.base (base_r[g]),
			.attr (rmpu_pkg::rmpu_attr_t'(attr_r[g])),
			.addr (acc.addr),
			.hit  (hit_vec[g])
		);
	end

	always_comb begin
		win     = 3'h0;
		any_hit = 1'b0;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (hit_vec[i]) begin
				win     = 3'(i);
				any_hit = 1'b1;
			end
		end
		win_attr = rmpu_pkg::rmpu_attr_t'(attr_r[win]);
	end

	always_comb begin
		res_nxt        = '0;
		res_nxt.region = win;
		res_nxt.hit    = ctrl_en_r && any_hit;
		if (!ctrl_en_r || !any_hit) begin
			res_nxt.mem_type = rmpu_pkg::rmpu_mem_default;
			res_nxt.mm_fault = ctrl_en_r && !(acc.priv && privdef_r);
		end else begin
			res_nxt.perm_fault = !perm_ok(win_attr.ap, acc.priv, acc.write) ||
				(acc.fetch && win_attr.xn);
			res_nxt.mm_fault = res_nxt.perm_fault;
			case (win_attr.type_extension_field)
				3'h0: begin
					if (!win_attr.c) begin
						res_nxt.mem_type = win_attr.b ? rmpu_pkg::rmpu_mem_device
							: rmpu_pkg::rmpu_mem_strong;
						res_nxt.shareable = 1'b1;
					end else begin
						res_nxt.mem_type  = rmpu_pkg::rmpu_mem_normal;
						res_nxt.shareable = win_attr.s;
						res_nxt.outer     = 2'h2;
						res_nxt.inner     = 2'h2;
					end
				end
				3'h1: begin
					if (win_attr.c == win_attr.b) begin
						res_nxt.mem_type  = rmpu_pkg::rmpu_mem_normal;
						res_nxt.shareable = win_attr.s;
						res_nxt.outer     = {1'b0, win_attr.c};
						res_nxt.inner     = {1'b0, win_attr.c};
					end else begin
						res_nxt.mem_type = rmpu_pkg::rmpu_mem_reserved;
					end
				end
				3'h2: begin
					res_nxt.mem_type = (!win_attr.c && !win_attr.b) ?
						rmpu_pkg::rmpu_mem_device : rmpu_pkg::rmpu_mem_reserved;
				end
				3'h3: begin
					res_nxt.mem_type = rmpu_pkg::rmpu_mem_reserved;
				end
				default: begin
					res_nxt.mem_type  = rmpu_pkg::rmpu_mem_normal;
					res_nxt.shareable = win_attr.s;
					res_nxt.outer     = win_attr.type_extension_field[1:0];
					res_nxt.inner     = {win_attr.c, win_attr.b};
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chk_valid_r <= 1'b0;
			res_r       <= '0;
		end else if (ce) begin
			chk_valid_r <= acc_valid;
			if (acc_valid) begin
				res_r <= res_nxt;
			end
		end
	end

	assign chk_valid  = chk_valid_r;
	assign chk_result = res_r;
	assign mpu_active = ctrl_en_r;

	// ---------------- assertions ----------------
	property p_reset_off;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> !ctrl_en_r && (attr_r[0][0] == 1'b0);
	endproperty
	a_reset_off: assert property (p_reset_off)
		else $error("unit not inactive after reset");

	property p_unprotected_pass;
		@(posedge aclk) disable iff (!aresetn)
		(ce && acc_valid && !ctrl_en_r) |=> chk_valid && !chk_result.mm_fault;
	endproperty
	a_unprotected_pass: assert property (p_unprotected_pass)
		else $error("fault raised while unit inactive");

	property p_no_region_fault;
		@(posedge aclk) disable iff (!aresetn)
		(ce && acc_valid && ctrl_en_r && !any_hit && !acc.priv) |=> chk_result.mm_fault;
	endproperty
	a_no_region_fault: assert property (p_no_region_fault)
		else $error("unprivileged miss did not fault");

	property p_background_priv;
		@(posedge aclk) disable iff (!aresetn)
		(ce && acc_valid && ctrl_en_r && !any_hit && acc.priv && privdef_r)
			|=> !chk_result.mm_fault && chk_result.mem_type == rmpu_pkg::rmpu_mem_default;
	endproperty
	a_background_priv: assert property (p_background_priv)
		else $error("privileged background access refused");

	property p_top_wins;
		@(posedge aclk) disable iff (!aresetn)
		(ce && acc_valid && ctrl_en_r && hit_vec[NUM_REGIONS-1])
			|=> chk_result.hit && chk_result.region == 3'(NUM_REGIONS - 1);
	endproperty
	a_top_wins: assert property (p_top_wins)
		else $error("highest region did not win");

	property p_never_exec;
		@(posedge aclk) disable iff (!aresetn)
		(ce && acc_valid && ctrl_en_r && any_hit && acc.fetch && win_attr.xn)
			|=> chk_result.perm_fault && chk_result.mm_fault;
	endproperty
	a_never_exec: assert property (p_never_exec)
		else $error("fetch from never-execute region passed");

	property p_strong_decode;
		@(posedge aclk) disable iff (!aresetn)
		(ce && acc_valid && ctrl_en_r && any_hit && win_attr.type_extension_field == 3'h0 &&
			!win_attr.c && !win_attr.b) |=> chk_result.mem_type == rmpu_pkg::rmpu_mem_strong;
	endproperty
	a_strong_decode: assert property (p_strong_decode)
		else $error("strongly ordered code misdecoded");

	property p_valid_reselect;
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_fire && wr_is_base && (&w_strb_r) && w_data_r[`RMPU_BASE_VALID_BIT])
			|=> sel_r == $past(w_data_r[2:0]) && bvalid_r;
	endproperty
	a_valid_reselect: assert property (p_valid_reselect)
		else $error("base write with valid flag did not reselect");

	property p_byte_lane;
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_fire && wr_is_attr && w_strb_r == 4'h1 && int'(sel_r) < NUM_REGIONS)
			|=> attr_r[$past(sel_r)][31:8] == $past(attr_r[sel_r][31:8]);
	endproperty
	a_byte_lane: assert property (p_byte_lane)
		else $error("byte write touched other lanes");

endmodule // rmpu_top
`default_nettype wire

// *** shared/rmpu_defs.svh ***
`ifndef RMPU_DEFS_SVH
`define RMPU_DEFS_SVH

// register byte addresses inside the block window
`define RMPU_ADDR_W           12
`define RMPU_OFF_TYPE         12'hd90
`define RMPU_OFF_CTRL         12'hd94
`define RMPU_OFF_SELECT       12'hd98
`define RMPU_OFF_BASE         12'hd9c
`define RMPU_OFF_ATTR         12'hda0
`define RMPU_OFF_BASE1        12'hda4
`define RMPU_OFF_ATTR1        12'hda8
`define RMPU_OFF_BASE2        12'hdac
`define RMPU_OFF_ATTR2        12'hdb0
`define RMPU_OFF_BASE3        12'hdb4
`define RMPU_OFF_ATTR3        12'hdb8

// field positions
`define RMPU_CTRL_EN_BIT      0
`define RMPU_CTRL_PRIVDEF_BIT 2
`define RMPU_CTRL_WMASK       32'h0000_0005
`define RMPU_BASE_VALID_BIT   4
`define RMPU_BASE_ADDR_LSB    5
`define RMPU_TYPE_COUNT_LSB   8
`define RMPU_ATTR_WMASK       32'h173f_ff3f

// reset values
`define RMPU_CTRL_RESET       32'h0000_0000
`define RMPU_SEL_RESET        3'h0
`define RMPU_BASE_RESET       27'h000_0000
`define RMPU_ATTR_RESET       32'h0000_0000

// size field limits: 32 bytes is the least region, 256 bytes the least with subregions
`define RMPU_SIZE_MIN         5'h04
`define RMPU_SIZE_SUBREG      5'h07

// bus answers
`define RMPU_RESP_OKAY        2'h0
`define RMPU_RESP_SLVERR      2'h2

`endif

// *** shared/rmpu_pkg.sv ***
package rmpu_pkg;

	// one access from the core
	typedef struct packed {
		logic        fetch;
		logic        write;
		logic        priv;
		logic [31:0] addr;
	} rmpu_access_t;

	// attribute/size word layout
	typedef struct packed {
		logic [2:0] rsv_hi;
		logic       xn;
		logic       rsv_27;
		logic [2:0] ap;
		logic [1:0] rsv_mid;
		logic [2:0] type_extension_field;
		logic       s;
		logic       c;
		logic       b;
		logic [7:0] subregion_disable_mask;
		logic [1:0] rsv_lo;
		logic [4:0] size;
		logic       en;
	} rmpu_attr_t;

	typedef enum logic [2:0] {
		rmpu_mem_default  = 3'h0,
		rmpu_mem_strong   = 3'h1,
		rmpu_mem_device   = 3'h2,
		rmpu_mem_normal   = 3'h3,
		rmpu_mem_reserved = 3'h4
	} rmpu_mem_t;

	typedef struct packed {
		logic      mm_fault;
		logic      perm_fault;
		logic      hit;
		logic [2:0] region;
		rmpu_mem_t mem_type;
		logic      shareable;
		logic [1:0] outer;
		logic [1:0] inner;
	} rmpu_result_t;

endpackage

// *** verification/rmpu_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module rmpu_core_model (
	// clock
	input  wire logic                   aclk,
	// access port toward the unit
	output var logic                    acc_valid,
	output var rmpu_pkg::rmpu_access_t  acc,
	input  wire logic                   chk_valid,
	input  wire rmpu_pkg::rmpu_result_t chk_result
);
	initial begin
		acc_valid = 1'b0;
		acc = '0;
	end

	// one access; the result is looked at in the single cycle chk_valid stands
	task automatic issue(input logic [2:0] kind, input logic [31:0] a,
		output rmpu_pkg::rmpu_result_t r, output logic v);
		@(posedge aclk);
		acc_valid <= 1'b1;
		acc <= {kind, a};
		@(posedge aclk);
		acc_valid <= 1'b0;
		// a released address does not keep its last value
		acc <= {kind, ~a};
		#1;
		v = chk_valid;
		r = chk_result;
	endtask
endmodule // rmpu_core_model
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rmpu_defs.svh"

module testbench;
	localparam logic [2:0]  RD_U = 3'b000;
	localparam logic [2:0]  RD_P = 3'b001;
	localparam logic [2:0]  FE_U = 3'b100;
	localparam logic [31:0] A0   = 32'h2000_0000;
	// type ext, c/b, memory type, outer, inner
	localparam logic [11:0] MT[9] = '{12'h010, 12'h0a0, 12'h1ba, 12'h230, 12'h2c0, 12'h3b5,
		12'hcb9, 12'h420, 12'h640};

	logic                   aclk = 1'b0;
	logic                   aresetn = 1'b0;
	logic [11:0]            s_axi_awaddr = '0;
	logic [11:0]            s_axi_araddr = '0;
	logic [31:0]            s_axi_wdata = '0;
	logic [3:0]             s_axi_wstrb = '0;
	logic                   s_axi_awvalid = 1'b0;
	logic                   s_axi_wvalid = 1'b0;
	logic                   s_axi_bready = 1'b0;
	logic                   s_axi_arvalid = 1'b0;
	logic                   s_axi_rready = 1'b0;
	logic                   ce = 1'b1;
	logic                   frozen_v;
	logic                   s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                   s_axi_arready, s_axi_rvalid, mpu_active;
	logic                   acc_valid, chk_valid;
	logic [1:0]             s_axi_bresp, s_axi_rresp, resp;
	logic [31:0]            s_axi_rdata, rdat;
	rmpu_pkg::rmpu_access_t acc;
	rmpu_pkg::rmpu_result_t chk_result, last;
	rmpu_pkg::rmpu_attr_t   at;
	int                     bad_count = 0;
	int                     samples_checked = 0;

	always #50 aclk = ~aclk;

	rmpu_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc, .chk_valid, .chk_result,
		.mpu_active);

	rmpu_core_model core (.aclk, .acc_valid, .acc, .chk_valid, .chk_result);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// callers give full strobes on every register but attr
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(negedge aclk); while (!s_axi_awready);
				@(posedge aclk);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(negedge aclk); while (!s_axi_wready);
				@(posedge aclk);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(negedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	// an enabled region is switched off before it is rewritten
	task automatic rewrite(input logic [31:0] d);
		wr(`RMPU_OFF_ATTR, 32'h0, 4'h1);
		wr(`RMPU_OFF_ATTR, d, 4'hf);
	endtask

	// expectation packs mm fault, permission fault, hit, region
	task automatic probe(input logic [2:0] k, input logic [31:0] a, input logic [5:0] e);
		logic v;
		core.issue(k, a, last, v);
		chk(v, 1'b1);
		chk({last.mm_fault, last.perm_fault, last.hit, last.region}, e);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`RMPU_OFF_CTRL);
		chk(rdat, 32'h0); // unit off
		rd(`RMPU_OFF_ATTR);
		chk(rdat, 32'h0); // region off
		rd(`RMPU_OFF_TYPE);
		chk(rdat, 32'h0000_0800); // eight regions
		chk(mpu_active, 1'b0); // inactive
		probe(RD_U, A0, 6'h00); // no fault while off
		chk(last.mem_type, rmpu_pkg::rmpu_mem_default); // default map
		$display("test reset done");
		wr(`RMPU_OFF_BASE, A0, 4'hf);
		for (int i = 3; i >= 0; i--)
			wr(`RMPU_OFF_ATTR, 32'h0302_0017, 4'h1 << i);
		rd(`RMPU_OFF_ATTR);
		chk(rdat, 32'h0302_0017); // one lane at a time
		wr(`RMPU_OFF_BASE1, A0 | 32'h11, 4'hf);
		wr(`RMPU_OFF_ATTR1, 32'h0101_0013, 4'hf);
		chk(resp, `RMPU_RESP_OKAY); // alias write accepted
		rd(`RMPU_OFF_SELECT);
		chk(rdat, 32'h1); // selection from base write
		chk(resp, `RMPU_RESP_OKAY); // selection readable
		rd(`RMPU_OFF_BASE);
		chk(rdat, A0 | 32'h1); // alias reached region 1
		wr(`RMPU_OFF_TYPE, 32'hffff_ffff, 4'hf);
		rd(`RMPU_OFF_TYPE);
		chk(rdat, 32'h0000_0800); // read only
		wr(12'hdbc, 32'h1, 4'hf);
		chk(resp, `RMPU_RESP_SLVERR); // no register past the window
		rd(12'hdbc);
		chk(resp, `RMPU_RESP_SLVERR); // no register past the window
		chk(rdat, 32'h0); // unmapped reads zero
		ce <= 1'b0;
		core.issue(RD_U, A0, last, frozen_v);
		chk(frozen_v, 1'b0); // frozen unit takes no access
		chk(s_axi_awready, 1'b0); // frozen unit takes no write
		@(posedge aclk);
		ce <= 1'b1;
		$display("test registers done");
		wr(`RMPU_OFF_CTRL, 32'h1, 4'hf);
		chk(mpu_active, 1'b1); // enabled by software
		probe(RD_U, A0 + 32'h100, 6'h39); // region 1 refuses
		probe(RD_P, A0 + 32'h100, 6'h09); // privileged allowed
		chk(last.mem_type, rmpu_pkg::rmpu_mem_device); // device
		probe(FE_U, A0 + 32'h800, 6'h08); // fetch uses same regions
		chk(last.mem_type, rmpu_pkg::rmpu_mem_normal); // normal
		probe(RD_P, 32'h3000_0000, 6'h20); // miss faults
		wr(`RMPU_OFF_CTRL, 32'h5, 4'hf);
		probe(RD_P, 32'h3000_0000, 6'h00); // background for privileged
		probe(RD_U, 32'h3000_0000, 6'h20); // not for unprivileged
		$display("test access done");
		// masks set only on regions of 256 bytes or more
		wr(`RMPU_OFF_SELECT, 32'h1, 4'hf);
		rewrite(32'h0101_0113);
		probe(RD_P, A0 + 32'h10, 6'h08); // falls to region 0
		probe(RD_P, A0 + 32'h390, 6'h09); // top subregion kept
		wr(`RMPU_OFF_SELECT, 32'h0, 4'hf);
		rewrite(32'h0302_0117);
		probe(RD_U, A0 + 32'h10, 6'h20); // nothing left, fault
		$display("test subregions done");
		foreach (MT[i]) begin
			at = '0;
			at.en = 1'b1;
			at.size = 5'd11;
			at.ap = 3'h3;
			at.s = (i % 2 == 1);
			{at.type_extension_field, at.c, at.b} = MT[i][11:7];
			rewrite(at);
			probe(RD_P, A0 + 32'h800, 6'h08); // attributes never fault
			chk(last.mem_type, MT[i][6:4]); // type decode
			chk(last.shareable, (MT[i][6:4] == 3'h3) ? at.s : (MT[i][11:9] == 3'h0));
			if (MT[i][6:4] == 3'h3)
				chk({last.outer, last.inner}, MT[i][3:0]); // policies
		end
		$display("test memory types done");
		wr(`RMPU_OFF_BASE2, A0 | 32'h17, 4'hf);
		wr(`RMPU_OFF_ATTR2, 32'h1302_0013, 4'hf);
		probe(RD_U, A0 + 32'h200, 6'h0f); // region 7 over regions 0 and 1
		probe(FE_U, A0 + 32'h200, 6'h3f); // never-execute refuses a fetch
		$display("test region seven done");
		conclude();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		conclude();
	end
endmodule // testbench
`default_nettype wire
